// >>> dreem_drv.sv
// host software model driving the register port
`timescale 1ns/1ps
module dreem_drv (
  input wire logic i_clk,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [31:0] i_rdata
);
  initial begin
    o_addr = 8'hFF;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle write, address and data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask
  // write then read on the next cycle, so a stored word is seen at once
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    q = i_rdata;
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    q = i_rdata;
  endtask
endmodule

// >>> dreem_pkg.sv
// constants, field layouts and carrier types of the descriptor ram emulation block
// Functional notes
// - a 512 byte descriptor ram holds usb descriptors in place of eeprom contents
// - ram location 0 belongs to the language id descriptor unless its stored length is zero
// - device descriptors go out with size 0x12 and type 0x1 whatever is stored
// - configuration descriptors go out with type 0x2 whatever is stored
// - all string lengths zero means no language id descriptor is served
// - with emulation enabled flags come from registers, and descriptors from ram unless ram test mode is on
// - reset protection keeps ram and listed registers through all but power-on reset
// - eeprom load with emulation disabled sets station address, boost, indicator select and pin wake enables
// - in eeprom operation flag fields come from eeprom and are hidden from software
package dreem_pkg;
  localparam int unsigned DREEM_RAM_BYTES = 512;
  localparam int unsigned DREEM_RAM_WORDS = DREEM_RAM_BYTES / 4;
  localparam int unsigned DREEM_NUM_DESC = 10;
  localparam int unsigned DREEM_WAKE_PINS = 11;
  localparam int unsigned DREEM_BOOST_W = 2;
  localparam logic [7:0] DREEM_OFS_HARDWARE_CONFIG_REG = 8'h00;
  localparam logic [7:0] DREEM_OFS_FLAG = 8'h04;
  localparam logic [7:0] DREEM_OFS_HS_LEN = 8'h08;
  localparam logic [7:0] DREEM_OFS_FS_LEN = 8'h0C;
  localparam logic [7:0] DREEM_OFS_STR_A = 8'h10;
  localparam logic [7:0] DREEM_OFS_STR_B = 8'h14;
  localparam logic [7:0] DREEM_OFS_ADDR_UP = 8'h18;
  localparam logic [7:0] DREEM_OFS_ADDR_LO = 8'h1C;
  localparam logic [7:0] DREEM_OFS_IND_CFG = 8'h20;
  localparam logic [7:0] DREEM_OFS_WAKE = 8'h24;
  localparam logic [7:0] DREEM_OFS_DP_SEL = 8'h28;
  localparam logic [7:0] DREEM_OFS_DP_ADDR = 8'h2C;
  localparam logic [7:0] DREEM_OFS_DP_DATA = 8'h30;
  localparam int unsigned DREEM_HW_EMUL_BIT = 0;
  localparam int unsigned DREEM_HW_PROTECT_BIT = 1;
  localparam int unsigned DREEM_HW_TEST_BIT = 2;
  localparam int unsigned DREEM_HW_BOOST_LSB = 4;
  localparam int unsigned DREEM_FLAG_POWER_BIT = 6;
  localparam int unsigned DREEM_FLAG_WAKEUP_BIT = 5;
  localparam int unsigned DREEM_SEL_LANG = 0;
  localparam int unsigned DREEM_SEL_STR_LAST = 5;
  localparam int unsigned DREEM_SEL_HS_DEV = 6;
  localparam int unsigned DREEM_SEL_HS_CFG = 7;
  localparam int unsigned DREEM_SEL_FS_DEV = 8;
  localparam int unsigned DREEM_SEL_FS_CFG = 9;
  localparam logic [7:0] DREEM_DEV_SIZE = 8'h12;
  localparam logic [7:0] DREEM_DEV_TYPE = 8'h01;
  localparam logic [7:0] DREEM_CFG_TYPE = 8'h02;
  localparam logic [9:0] DREEM_CFG_ATTR_OFS = 10'h007;
  localparam logic [7:0] DREEM_LEN_RST = 8'h00;
  localparam logic [31:0] DREEM_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] DREEM_BOOST_RST = 2'h0;

  typedef struct packed {
    logic [47:0] station_address;
    logic [DREEM_BOOST_W-1:0] line_drive_boost;
    logic indicator_select;
    logic [DREEM_WAKE_PINS-1:0] pin_wake_enables;
    logic power_source_flag;
    logic remote_wakeup_flag;
  } dreem_ee_load_t;

  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] offset;
  } dreem_desc_req_t;

  typedef struct packed {
    logic hit;
    logic [7:0] length;
    logic [7:0] data;
  } dreem_desc_ans_t;
endpackage

// >>> dreem_top.sv
// descriptor ram, attribute registers and software-set fields for eeprom-less operation
`timescale 1ns/1ps
module dreem_top (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_soft_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_ee_load,
  input wire dreem_pkg::dreem_ee_load_t i_ee_cfg,
  input wire logic i_desc_req,
  input wire dreem_pkg::dreem_desc_req_t i_desc,
  output logic o_desc_valid,
  output dreem_pkg::dreem_desc_ans_t o_desc,
  output logic o_emulation_enable,
  output logic [47:0] o_station_address,
  output logic [dreem_pkg::DREEM_BOOST_W-1:0] o_line_drive_boost,
  output logic o_indicator_select,
  output logic [dreem_pkg::DREEM_WAKE_PINS-1:0] o_pin_wake_enables,
  output logic o_power_source_flag,
  output logic o_remote_wakeup_flag
);
  function automatic logic [9:0] dreem_align4(input logic [7:0] len);
    logic [9:0] s;
    s = {2'h0, len} + 10'h003;
    return {s[9:2], 2'h0};
  endfunction

  function automatic logic dreem_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // configuration state
  logic emulation_enable, reset_protect, ram_test_mode_enable, indicator_select, dp_select;
  logic next_emulation_enable, next_reset_protect, next_ram_test_mode_enable;
  logic next_indicator_select, next_dp_select;
  logic [dreem_pkg::DREEM_BOOST_W-1:0] line_drive_boost, next_line_drive_boost;
  logic power_source_flag, remote_wakeup_flag, next_power_source_flag, next_remote_wakeup_flag;
  logic [7:0] len [dreem_pkg::DREEM_NUM_DESC], next_len [dreem_pkg::DREEM_NUM_DESC];
  logic [15:0] station_address_upper, next_station_address_upper;
  logic [31:0] station_address_lower, next_station_address_lower;
  logic [dreem_pkg::DREEM_WAKE_PINS-1:0] pin_wake_enables, next_pin_wake_enables;
  logic [6:0] dp_addr, next_dp_addr;
  // ram and answer state
  logic [31:0] ram [dreem_pkg::DREEM_RAM_WORDS], next_ram [dreem_pkg::DREEM_RAM_WORDS];
  logic [31:0] next_rdata;
  logic next_desc_valid;
  dreem_pkg::dreem_desc_ans_t next_desc;

  // descriptor start addresses, each rounded to a whole word
  logic [9:0] base [dreem_pkg::DREEM_NUM_DESC];
  assign base[0] = 10'h000;
  for (genvar g = 1; g < dreem_pkg::DREEM_NUM_DESC; g++) begin : g_base
    assign base[g] = base[g-1] + dreem_align4(len[g-1]);
  end

  logic dp_write, strings_absent, is_dev, is_cfg;
  assign is_dev = i_desc.sel == 4'(dreem_pkg::DREEM_SEL_HS_DEV) ||
                  i_desc.sel == 4'(dreem_pkg::DREEM_SEL_FS_DEV);
  assign is_cfg = i_desc.sel == 4'(dreem_pkg::DREEM_SEL_HS_CFG) ||
                  i_desc.sel == 4'(dreem_pkg::DREEM_SEL_FS_CFG);
  logic [9:0] high_speed_length_attrs_addr, full_speed_length_attrs_addr;
  assign dp_write = i_wr && dreem_hit(i_addr, dreem_pkg::DREEM_OFS_DP_DATA) && dp_select;
  assign high_speed_length_attrs_addr = base[dreem_pkg::DREEM_SEL_HS_CFG] + dreem_pkg::DREEM_CFG_ATTR_OFS;
  assign full_speed_length_attrs_addr = base[dreem_pkg::DREEM_SEL_FS_CFG] + dreem_pkg::DREEM_CFG_ATTR_OFS;
  assign strings_absent = (len[1] | len[2] | len[3] | len[4] | len[5]) == 8'h00;

  always_comb begin
    logic [7:0] abyte;
    abyte = 8'h00;
    next_emulation_enable = emulation_enable;
    next_reset_protect = reset_protect;
    next_ram_test_mode_enable = ram_test_mode_enable;
    next_line_drive_boost = line_drive_boost;
    next_power_source_flag = power_source_flag;
    next_remote_wakeup_flag = remote_wakeup_flag;
    next_len = len;
    next_station_address_upper = station_address_upper;
    next_station_address_lower = station_address_lower;
    next_indicator_select = indicator_select;
    next_pin_wake_enables = pin_wake_enables;
    next_dp_select = dp_select;
    next_dp_addr = dp_addr;
    if (i_soft_reset) begin
      next_dp_select = 1'b0;
      next_dp_addr = 7'h00;
      if (!reset_protect) begin
        next_emulation_enable = 1'b0;
        next_ram_test_mode_enable = 1'b0;
        next_line_drive_boost = dreem_pkg::DREEM_BOOST_RST;
        next_power_source_flag = 1'b0;
        next_remote_wakeup_flag = 1'b0;
        next_len = '{default: dreem_pkg::DREEM_LEN_RST};
        next_station_address_upper = 16'h0000;
        next_station_address_lower = dreem_pkg::DREEM_WORD_RST;
        next_indicator_select = 1'b0;
        next_pin_wake_enables = '0;
      end
    end else begin
      if (i_wr) begin
        case (i_addr)
          dreem_pkg::DREEM_OFS_HARDWARE_CONFIG_REG: begin
            next_emulation_enable = i_wdata[dreem_pkg::DREEM_HW_EMUL_BIT];
            next_reset_protect = i_wdata[dreem_pkg::DREEM_HW_PROTECT_BIT];
            next_ram_test_mode_enable = i_wdata[dreem_pkg::DREEM_HW_TEST_BIT];
            next_line_drive_boost =
              i_wdata[dreem_pkg::DREEM_HW_BOOST_LSB +: dreem_pkg::DREEM_BOOST_W];
          end
          dreem_pkg::DREEM_OFS_FLAG: begin
            if (emulation_enable) begin
              next_power_source_flag = i_wdata[dreem_pkg::DREEM_FLAG_POWER_BIT];
              next_remote_wakeup_flag = i_wdata[dreem_pkg::DREEM_FLAG_WAKEUP_BIT];
            end
          end
          dreem_pkg::DREEM_OFS_HS_LEN: {next_len[7], next_len[6]} = i_wdata[15:0];
          dreem_pkg::DREEM_OFS_FS_LEN: {next_len[9], next_len[8]} = i_wdata[15:0];
          dreem_pkg::DREEM_OFS_STR_A:
            {next_len[3], next_len[2], next_len[1], next_len[0]} = i_wdata;
          dreem_pkg::DREEM_OFS_STR_B: {next_len[5], next_len[4]} = i_wdata[15:0];
          dreem_pkg::DREEM_OFS_ADDR_UP: next_station_address_upper = i_wdata[15:0];
          dreem_pkg::DREEM_OFS_ADDR_LO: next_station_address_lower = i_wdata;
          dreem_pkg::DREEM_OFS_IND_CFG: next_indicator_select = i_wdata[0];
          dreem_pkg::DREEM_OFS_WAKE:
            next_pin_wake_enables = i_wdata[dreem_pkg::DREEM_WAKE_PINS-1:0];
          dreem_pkg::DREEM_OFS_DP_SEL: next_dp_select = i_wdata[0];
          dreem_pkg::DREEM_OFS_DP_ADDR: next_dp_addr = i_wdata[6:0];
          default: ;
        endcase
      end
      // a ram write over a config attribute byte takes over the flags
      if (dp_write && len[dreem_pkg::DREEM_SEL_HS_CFG] != 8'h00 &&
          high_speed_length_attrs_addr[8:2] == dp_addr) begin
        abyte = i_wdata[8*high_speed_length_attrs_addr[1:0] +: 8];
        next_power_source_flag = abyte[dreem_pkg::DREEM_FLAG_POWER_BIT];
        next_remote_wakeup_flag = abyte[dreem_pkg::DREEM_FLAG_WAKEUP_BIT];
      end
      if (dp_write && len[dreem_pkg::DREEM_SEL_FS_CFG] != 8'h00 &&
          full_speed_length_attrs_addr[8:2] == dp_addr) begin
        abyte = i_wdata[8*full_speed_length_attrs_addr[1:0] +: 8];
        next_power_source_flag = abyte[dreem_pkg::DREEM_FLAG_POWER_BIT];
        next_remote_wakeup_flag = abyte[dreem_pkg::DREEM_FLAG_WAKEUP_BIT];
      end
      if (i_ee_load && !emulation_enable) begin
        {next_station_address_upper, next_station_address_lower} = i_ee_cfg.station_address;
        next_line_drive_boost = i_ee_cfg.line_drive_boost;
        next_indicator_select = i_ee_cfg.indicator_select;
        next_pin_wake_enables = i_ee_cfg.pin_wake_enables;
        next_power_source_flag = i_ee_cfg.power_source_flag;
        next_remote_wakeup_flag = i_ee_cfg.remote_wakeup_flag;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      emulation_enable <= 1'b0;
      reset_protect <= 1'b0;
      ram_test_mode_enable <= 1'b0;
      line_drive_boost <= dreem_pkg::DREEM_BOOST_RST;
      power_source_flag <= 1'b0;
      remote_wakeup_flag <= 1'b0;
      len <= '{default: dreem_pkg::DREEM_LEN_RST};
      station_address_upper <= 16'h0000;
      station_address_lower <= dreem_pkg::DREEM_WORD_RST;
      indicator_select <= 1'b0;
      pin_wake_enables <= '0;
      dp_select <= 1'b0;
      dp_addr <= 7'h00;
    end else begin
      emulation_enable <= next_emulation_enable;
      reset_protect <= next_reset_protect;
      ram_test_mode_enable <= next_ram_test_mode_enable;
      line_drive_boost <= next_line_drive_boost;
      power_source_flag <= next_power_source_flag;
      remote_wakeup_flag <= next_remote_wakeup_flag;
      len <= next_len;
      station_address_upper <= next_station_address_upper;
      station_address_lower <= next_station_address_lower;
      indicator_select <= next_indicator_select;
      pin_wake_enables <= next_pin_wake_enables;
      dp_select <= next_dp_select;
      dp_addr <= next_dp_addr;
    end
  end

  // descriptor ram, word-wide flip-flops
  always_comb begin
    next_ram = ram;
    if (i_soft_reset && !reset_protect) begin
      next_ram = '{default: dreem_pkg::DREEM_WORD_RST};
    end else if (!i_soft_reset && dp_write) begin
      next_ram[dp_addr] = i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ram <= '{default: dreem_pkg::DREEM_WORD_RST};
    end else begin
      ram <= next_ram;
    end
  end

  // register read data and descriptor answers
  always_comb begin
    logic [9:0] baddr;
    logic [7:0] elen;
    logic [31:0] word;
    baddr = 10'h000;
    elen = 8'h00;
    word = dreem_pkg::DREEM_WORD_RST;
    next_rdata = dreem_pkg::DREEM_WORD_RST;
    if (i_rd) begin
      case (i_addr)
        dreem_pkg::DREEM_OFS_HARDWARE_CONFIG_REG: begin
          next_rdata[dreem_pkg::DREEM_HW_EMUL_BIT] = emulation_enable;
          next_rdata[dreem_pkg::DREEM_HW_PROTECT_BIT] = reset_protect;
          next_rdata[dreem_pkg::DREEM_HW_TEST_BIT] = ram_test_mode_enable;
          next_rdata[dreem_pkg::DREEM_HW_BOOST_LSB +: dreem_pkg::DREEM_BOOST_W] =
            line_drive_boost;
        end
        dreem_pkg::DREEM_OFS_FLAG: begin
          next_rdata[dreem_pkg::DREEM_FLAG_POWER_BIT] = power_source_flag & emulation_enable;
          next_rdata[dreem_pkg::DREEM_FLAG_WAKEUP_BIT] =
            remote_wakeup_flag & emulation_enable;
        end
        dreem_pkg::DREEM_OFS_HS_LEN: next_rdata[15:0] = {len[7], len[6]};
        dreem_pkg::DREEM_OFS_FS_LEN: next_rdata[15:0] = {len[9], len[8]};
        dreem_pkg::DREEM_OFS_STR_A: next_rdata = {len[3], len[2], len[1], len[0]};
        dreem_pkg::DREEM_OFS_STR_B: next_rdata[15:0] = {len[5], len[4]};
        dreem_pkg::DREEM_OFS_ADDR_UP: next_rdata[15:0] = station_address_upper;
        dreem_pkg::DREEM_OFS_ADDR_LO: next_rdata = station_address_lower;
        dreem_pkg::DREEM_OFS_IND_CFG: next_rdata[0] = indicator_select;
        dreem_pkg::DREEM_OFS_WAKE: next_rdata[dreem_pkg::DREEM_WAKE_PINS-1:0] = pin_wake_enables;
        dreem_pkg::DREEM_OFS_DP_SEL: next_rdata[0] = dp_select;
        dreem_pkg::DREEM_OFS_DP_ADDR: next_rdata[6:0] = dp_addr;
        dreem_pkg::DREEM_OFS_DP_DATA: next_rdata = dp_select ? ram[dp_addr] : 32'h0000_0000;
        default: next_rdata = dreem_pkg::DREEM_WORD_RST;
      endcase
    end
    next_desc_valid = i_desc_req;
    next_desc = '0;
    if (i_desc_req && i_desc.sel < 4'(dreem_pkg::DREEM_NUM_DESC)) begin
      elen = len[i_desc.sel];
      if (i_desc.sel == 4'(dreem_pkg::DREEM_SEL_LANG) && strings_absent) begin
        elen = 8'h00;
      end
      baddr = base[i_desc.sel] + {2'h0, i_desc.offset};
      word = ram[baddr[8:2]];
      if (emulation_enable && !ram_test_mode_enable && elen != 8'h00) begin
        next_desc.hit = 1'b1;
        next_desc.length = elen;
        next_desc.data = word[8*baddr[1:0] +: 8];
        if (is_dev) begin
          if (i_desc.offset == 8'h00) next_desc.data = dreem_pkg::DREEM_DEV_SIZE;
          if (i_desc.offset == 8'h01) next_desc.data = dreem_pkg::DREEM_DEV_TYPE;
        end
        if (is_cfg && i_desc.offset == 8'h01) begin
          next_desc.data = dreem_pkg::DREEM_CFG_TYPE;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= dreem_pkg::DREEM_WORD_RST;
      o_desc_valid <= 1'b0;
      o_desc <= '0;
    end else begin
      o_rdata <= next_rdata;
      o_desc_valid <= next_desc_valid;
      o_desc <= next_desc;
    end
  end

  assign o_emulation_enable = emulation_enable;
  assign o_station_address = {station_address_upper, station_address_lower};
  assign o_line_drive_boost = line_drive_boost;
  assign o_indicator_select = indicator_select;
  assign o_pin_wake_enables = pin_wake_enables;
  assign o_power_source_flag = power_source_flag;
  assign o_remote_wakeup_flag = remote_wakeup_flag;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_ram_store;
    i_wr && dreem_hit(i_addr, dreem_pkg::DREEM_OFS_DP_DATA) && dp_select && !i_soft_reset
    ##1 (i_rd && dreem_hit(i_addr, dreem_pkg::DREEM_OFS_DP_DATA) && !i_soft_reset)
    |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_ram_store: assert property (p_ram_store) else $error("ram word not read back");
  property p_dev_size;
    i_desc_req && is_dev && i_desc.offset == 8'h00 |=> !o_desc.hit || o_desc.data == 8'h12;
  endproperty
  a_dev_size: assert property (p_dev_size) else $error("device size not 0x12");
  property p_dev_type;
    i_desc_req && is_dev && i_desc.offset == 8'h01 |=> !o_desc.hit || o_desc.data == 8'h01;
  endproperty
  a_dev_type: assert property (p_dev_type) else $error("device type not 0x1");
  property p_cfg_type;
    i_desc_req && is_cfg && i_desc.offset == 8'h01 |=> !o_desc.hit || o_desc.data == 8'h02;
  endproperty
  a_cfg_type: assert property (p_cfg_type) else $error("config type not 0x2");
  property p_lang_off;
    i_desc_req && i_desc.sel == 4'h0 && strings_absent |=> o_desc_valid && !o_desc.hit;
  endproperty
  a_lang_off: assert property (p_lang_off) else $error("language id served");
  property p_emul_src;
    i_desc_req && emulation_enable && !ram_test_mode_enable && i_desc.sel == 4'h6 &&
    len[6] != 8'h00 |=> o_desc.hit && o_desc.length == $past(len[6]);
  endproperty
  a_emul_src: assert property (p_emul_src) else $error("ram descriptor not served");
  property p_no_emul;
    o_desc_valid && !$past(emulation_enable) |-> !o_desc.hit;
  endproperty
  a_no_emul: assert property (p_no_emul) else $error("ram served while disabled");
  property p_protect;
    i_soft_reset && reset_protect |=> $stable(o_station_address) && $stable(len[6]) &&
      $stable(o_emulation_enable);
  endproperty
  a_protect: assert property (p_protect) else $error("protected state lost");
  property p_ee_load;
    i_ee_load && !emulation_enable && !i_soft_reset
    |=> o_station_address == $past(i_ee_cfg.station_address) &&
        o_pin_wake_enables == $past(i_ee_cfg.pin_wake_enables);
  endproperty
  a_ee_load: assert property (p_ee_load) else $error("eeprom values not loaded");
  property p_flag_hidden;
    i_rd && dreem_hit(i_addr, dreem_pkg::DREEM_OFS_FLAG) && !emulation_enable |=> o_rdata == 0;
  endproperty
  a_flag_hidden: assert property (p_flag_hidden) else $error("flags visible");
  c_ram_served: cover property (o_desc_valid && o_desc.hit);
  c_protected_reset: cover property (i_soft_reset && reset_protect && emulation_enable);
  c_ee_load: cover property (i_ee_load && !emulation_enable);
endmodule

// >>> dreem_top_tb.sv
// self-checking bench of the descriptor ram emulation block
`timescale 1ns/1ps
module dreem_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic srst = 1'b0;
  logic [7:0] a;
  logic [31:0] wd, rdat, q;
  logic wr, rd, eel = 1'b0, dreq = 1'b0, dv, emul, ind, pw, rw;
  dreem_pkg::dreem_ee_load_t eec = '0;
  dreem_pkg::dreem_desc_req_t dsel = '0;
  dreem_pkg::dreem_desc_ans_t dans;
  logic [47:0] sta;
  logic [1:0] bst;
  logic [10:0] wk;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  always #2.5 clk = ~clk;
  dreem_drv drv (.i_clk(clk), .o_addr(a), .o_wdata(wd), .o_wr(wr), .o_rd(rd), .i_rdata(rdat));
  dreem_top dut (.i_clk(clk), .i_reset_n(rst_n), .i_soft_reset(srst), .i_addr(a),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_ee_load(eel), .i_ee_cfg(eec),
    .i_desc_req(dreq), .i_desc(dsel), .o_desc_valid(dv), .o_desc(dans),
    .o_emulation_enable(emul), .o_station_address(sta), .o_line_drive_boost(bst),
    .o_indicator_select(ind), .o_pin_wake_enables(wk), .o_power_source_flag(pw),
    .o_remote_wakeup_flag(rw));
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one descriptor byte request, answer checked one cycle later
  task automatic dsc(input logic [3:0] s, input logic [7:0] o, input logic [16:0] e);
    @(posedge clk);
    dreq <= 1'b1;
    dsel <= '{s, o};
    @(posedge clk);
    dreq <= 1'b0;
    #1;
    chk({dv, dans}, {1'b1, e});
  endtask
  task automatic pulse_srst();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    drv.rd(8'h00, q);
    chk(q, 0);
    drv.wr(8'h04, 32'h60);
    drv.rd(8'h04, q);
    chk(q, 0);
    drv.wr(8'h00, 32'h34);
    drv.wr(8'h18, 32'hBEEF);
    drv.wr(8'h1C, 32'h01234567);
    drv.wr(8'h20, 32'h1);
    drv.wr(8'h24, 32'h7FF);
    chk(sta, 48'hBEEF01234567);
    chk({bst, ind, wk}, {2'h3, 1'b1, 11'h7FF});
    drv.wr(8'h08, 32'h1212);
    drv.wr(8'h0C, 32'h12);
    drv.wr(8'h28, 32'h1);
    drv.wr(8'h2C, 32'h0);
    drv.wr(8'h30, 32'h02001211);
    drv.wr(8'h2C, 32'h1);
    drv.wr(8'h30, 32'h40000000);
    drv.wr(8'h2C, 32'h4);
    drv.wr(8'h30, 32'h00000100);
    drv.wr(8'h2C, 32'h5);
    drv.wr(8'h30, 32'hAABBCCDD);
    drv.wr(8'h2C, 32'h6);
    drv.wr(8'h30, 32'h40000000);
    drv.wr(8'h2C, 32'h7F);
    drv.wr_rd(8'h30, 32'h5A5A0F0F, q);
    chk(q, 32'h5A5A0F0F);
    drv.wr(8'h2C, 32'h0);
    drv.rd(8'h30, q);
    chk(q, 32'h02001211);
    dsc(4'd6, 8'd0, 17'h0);
    drv.wr(8'h00, 32'h35);
    dsc(4'd6, 8'd0, 17'h0);
    drv.wr(8'h00, 32'h31);
    chk({emul, pw, rw}, 3'b110);
    dsc(4'd6, 8'd0, {1'b1, 8'h12, 8'h12});
    dsc(4'd6, 8'd1, {1'b1, 8'h12, 8'h01});
    dsc(4'd6, 8'd2, {1'b1, 8'h12, 8'h00});
    dsc(4'd6, 8'd7, {1'b1, 8'h12, 8'h40});
    dsc(4'd6, 8'd16, {1'b1, 8'h12, 8'h00});
    dsc(4'd6, 8'd17, {1'b1, 8'h12, 8'h01});
    dsc(4'd7, 8'd0, {1'b1, 8'h12, 8'hDD});
    dsc(4'd7, 8'd1, {1'b1, 8'h12, 8'h02});
    dsc(4'd8, 8'd0, {1'b1, 8'h12, 8'h12});
    dsc(4'd8, 8'd1, {1'b1, 8'h12, 8'h01});
    dsc(4'd0, 8'd0, 17'h0);
    dsc(4'd10, 8'd0, 17'h0);
    eec = '{48'h0A0B0C0D0E0F, 2'h2, 1'b1, 11'h155, 1'b1, 1'b1};
    @(posedge clk);
    eel <= 1'b1;
    @(posedge clk);
    eel <= 1'b0;
    #1;
    chk(sta, 48'hBEEF01234567);
    drv.wr(8'h00, 32'h33);
    pulse_srst();
    dsc(4'd6, 8'd0, {1'b1, 8'h12, 8'h12});
    chk(sta, 48'hBEEF01234567);
    drv.wr(8'h00, 32'h31);
    pulse_srst();
    dsc(4'd6, 8'd0, 17'h0);
    chk(sta, 0);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    eel <= 1'b1;
    @(posedge clk);
    eel <= 1'b0;
    #1;
    chk(sta, 48'h0A0B0C0D0E0F);
    chk({bst, ind, wk, pw, rw}, {2'h2, 1'b1, 11'h155, 2'b11});
    report_and_stop();
  end
endmodule

// >>> dreem_unused_guard.sv
// no logic of its own: the whole block sits in dreem_top
